// [design/ebp_port.sv]
`timescale 1ns/10ps
`default_nettype none
module ebp_port
	import ebp_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// pins
	input  wire logic [PINS-1:0]   pin_in,
	output logic [PINS-1:0]        pin_out,
	output logic [PINS-1:0]        pin_oe,
	output logic [PINS-1:0]        pull_up_en,
	output logic [PINS-1:0]        pull_down_en,
	// analog converter may sample the pin
	output logic [PINS-1:0]        analog_input_line
);

////////////////////////////////////////////////////////////////////////////////
	logic [7:0]        level_q;
	logic [7:0]        dir_q;
	logic [7:0]        cfg_lo_q;
	logic [7:0]        cfg_hi_q;
	logic [7:0]        sync1_q;
	logic [7:0]        sync2_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic              aw_have_d;
	logic              w_have_d;
	logic [15:0]       aw_idx_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              do_wr;
	logic              rvalid_d;
	logic [15:0]       ar_idx;
	logic [7:0]        level_view;

	assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign ar_idx = s_axi_araddr[ADDR_W-1:2];

////////////////////////////////////////////////////////////////////////////////
	// two flops before anything looks at the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// output pins read back the stored bit, input pins the synchronised level
	assign level_view = (level_q & ~dir_q) | (sync2_q & dir_q);

////////////////////////////////////////////////////////////////////////////////
	// write channel capture; address and data may come in either order
	always_comb begin
		aw_have_d = (aw_have_q | (s_axi_awvalid & s_axi_awready)) & ~do_wr;
		w_have_d = (w_have_q | (s_axi_wvalid & s_axi_wready)) & ~do_wr;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_idx_q <= 16'h0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			s_axi_awready <= ~aw_have_d;
			s_axi_wready <= ~w_have_d;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// register file; narrow registers sit in lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_q <= RST_REG;
			dir_q <= RST_REG;
			cfg_lo_q <= RST_REG;
			cfg_hi_q <= RST_REG;
		end else if (do_wr) begin
			if (aw_idx_q == IDX_LEVEL && wstrb_q[0]) begin
				level_q <= wdata_q[7:0];
			end
			if (aw_idx_q == IDX_DIR && wstrb_q[0]) begin
				dir_q <= wdata_q[7:0];
			end
			// word access at the lower address reaches both config bytes
			if (aw_idx_q == IDX_CFG_LO && wstrb_q[0]) begin
				cfg_lo_q <= wdata_q[7:0];
			end
			if (aw_idx_q == IDX_CFG_LO && wstrb_q[1]) begin
				cfg_hi_q <= wdata_q[15:8];
			end
			if (aw_idx_q == IDX_CFG_HI && wstrb_q[0]) begin
				cfg_hi_q <= wdata_q[7:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			if (aw_idx_q >= IDX_LEVEL && aw_idx_q <= IDX_CFG_HI) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// read channel; one read in flight, answer one cycle after acceptance
	assign rvalid_d = (s_axi_rvalid & ~s_axi_rready) | (s_axi_arvalid & s_axi_arready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rresp <= RESP_OKAY;
				unique case (ar_idx)
					IDX_LEVEL: s_axi_rdata <= {24'h000000, level_view};
					IDX_DIR: s_axi_rdata <= {24'h000000, dir_q};
					IDX_CFG_LO: s_axi_rdata <= {16'h0000, cfg_hi_q, cfg_lo_q};
					IDX_CFG_HI: s_axi_rdata <= {24'h000000, cfg_hi_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// per-pin driver; all pin controls registered so they never glitch
	for (genvar n = 0; n < PINS; n++) begin : g_pin
		logic [1:0] cfg;
		assign cfg = {cfg_hi_q[n], cfg_lo_q[n]};
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_out[n] <= 1'b0;
				pin_oe[n] <= 1'b0;
				pull_up_en[n] <= 1'b0;
				pull_down_en[n] <= 1'b0;
				analog_input_line[n] <= 1'b0;
			end else begin
				// converter use is only safe with the pin floating as hi-z output
				analog_input_line[n] <= ~dir_q[n] & (cfg == CFG_HIZ);
				pull_up_en[n] <= dir_q[n] & (cfg == CFG_NOD);
				pull_down_en[n] <= dir_q[n] & (cfg == CFG_POD);
				if (dir_q[n]) begin
					pin_out[n] <= 1'b0;
					pin_oe[n] <= 1'b0;
				end else begin
					unique case (cfg)
						CFG_HIZ: begin
							pin_out[n] <= 1'b0;
							pin_oe[n] <= 1'b0;
						end
						CFG_POD: begin
							pin_out[n] <= 1'b1;
							pin_oe[n] <= level_q[n];
						end
						CFG_NOD: begin
							pin_out[n] <= 1'b0;
							pin_oe[n] <= ~level_q[n];
						end
						CFG_CMOS: begin
							pin_out[n] <= level_q[n];
							pin_oe[n] <= 1'b1;
						end
					endcase
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	sequence s_cfg(logic [1:0] c);
		dir_q[0] == 1'b0 && {cfg_hi_q[0], cfg_lo_q[0]} == c;
	endsequence

	sequence s_rd_level;
		s_axi_arvalid && s_axi_arready && ar_idx == IDX_LEVEL;
	endsequence

	property p_reset_clear;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> level_q == 8'h00 && dir_q == 8'h00 && cfg_lo_q == 8'h00
			&& cfg_hi_q == 8'h00 && pin_oe == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");

	property p_cmos;
		@(posedge aclk) disable iff (!aresetn)
		s_cfg(CFG_CMOS) |=> pin_oe[0] && pin_out[0] == $past(level_q[0]);
	endproperty
	a_cmos: assert property (p_cmos) else $error("push-pull drive wrong");

	property p_hiz;
		@(posedge aclk) disable iff (!aresetn)
		s_cfg(CFG_HIZ) |=> !pin_oe[0] && analog_input_line[0];
	endproperty
	a_hiz: assert property (p_hiz) else $error("hi-z output drives");

	property p_pod;
		@(posedge aclk) disable iff (!aresetn)
		s_cfg(CFG_POD) |=> pin_oe[0] == $past(level_q[0]) && pin_out[0];
	endproperty
	a_pod: assert property (p_pod) else $error("p open drain wrong");

	property p_nod;
		@(posedge aclk) disable iff (!aresetn)
		s_cfg(CFG_NOD) |=> pin_oe[0] == !$past(level_q[0]) && !pin_out[0];
	endproperty
	a_nod: assert property (p_nod) else $error("n open drain wrong");

	property p_input;
		@(posedge aclk) disable iff (!aresetn)
		dir_q[0] |=> !pin_oe[0] && pull_up_en[0] == ($past(cfg_hi_q[0]) & !$past(cfg_lo_q[0]))
			&& pull_down_en[0] == (!$past(cfg_hi_q[0]) & $past(cfg_lo_q[0]));
	endproperty
	a_input: assert property (p_input) else $error("input termination wrong");

	property p_sync;
		@(posedge aclk) disable iff (!aresetn)
		!$past(aresetn) == 1'b0 && !$past(aresetn, 2) == 1'b0 |-> sync2_q == $past(pin_in, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("synchroniser latency wrong");

	property p_read_level;
		@(posedge aclk) disable iff (!aresetn)
		s_rd_level |=> s_axi_rvalid
			&& s_axi_rdata[7:0] == (($past(level_q) & ~$past(dir_q)) | ($past(sync2_q) & $past(dir_q)));
	endproperty
	a_read_level: assert property (p_read_level) else $error("level readback wrong");

	property p_word_cfg;
		@(posedge aclk) disable iff (!aresetn)
		do_wr && aw_idx_q == IDX_CFG_LO && wstrb_q[1:0] == 2'h3
			|=> {cfg_hi_q, cfg_lo_q} == $past(wdata_q[15:0]);
	endproperty
	a_word_cfg: assert property (p_word_cfg) else $error("word config write wrong");

endmodule
`default_nettype wire

// [pkg/ebp_pkg.sv]
// Operation
// - eight independent pins; bit n of every register controls pin n
// - direction bit 0 means output, 1 means input; resets to output
// - output mode drives the level bit, shaped by the driver style
// - level read returns the written value for output pins
// - level read returns the sampled pin level for input pins
// - output style codes: 00 hi-z, 01 p open drain, 10 n open drain, 11 push-pull
// - input codes: 00 none, 01 pull-down, 10 pull-up, 11 none
// - config bits form two 8-bit arrays, one per config register
// - reset clears all four registers: every pin hi-z output
// - config registers reachable as bytes or one 16-bit word at the lower address
// - each pin may also carry one analog converter input
package ebp_pkg;
	localparam int PINS = 8;
	localparam int ADDR_W = 18;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_LEVEL = 16'hF230;
	localparam logic [15:0] IDX_DIR = 16'hF231;
	localparam logic [15:0] IDX_CFG_LO = 16'hF232;
	localparam logic [15:0] IDX_CFG_HI = 16'hF233;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] CFG_HIZ = 2'h0;
	localparam logic [1:0] CFG_POD = 2'h1;
	localparam logic [1:0] CFG_NOD = 2'h2;
	localparam logic [1:0] CFG_CMOS = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [tb/ebp_board.sv]
`timescale 1ns/10ps
`default_nettype none
module ebp_board
	import ebp_pkg::*;
(
	// clock
	input  wire logic            aclk,
	// device side
	input  wire logic [PINS-1:0] pin_out,
	input  wire logic [PINS-1:0] pin_oe,
	input  wire logic [PINS-1:0] pull_up_en,
	input  wire logic [PINS-1:0] pull_down_en,
	// board drivers
	input  wire logic [PINS-1:0] ext_val,
	input  wire logic [PINS-1:0] ext_en,
	output logic [PINS-1:0]      pin_in
);
	////////////////////////////////////////////////////////////////////////
	// a floating pin toggles so a stale level is never mistaken for a read
	logic [PINS-1:0] flt_q = 8'h00;
	always_ff @(posedge aclk) begin
		flt_q <= ~flt_q;
	end
	// device drive wins over the board; pulls only act on an idle wire
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & flt_q)));
endmodule
`default_nettype wire

// [tb/test_ebp_port.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ebp_port
	import ebp_pkg::*;
;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic [PINS-1:0]   pin_in, pin_out, pin_oe, pu, pd, ain, ext_val, ext_en;
	int                fails, tests_run;
	localparam logic [17:0] A_LV = {IDX_LEVEL, 2'h0};
	localparam logic [17:0] A_DR = {IDX_DIR, 2'h0};
	localparam logic [17:0] A_CL = {IDX_CFG_LO, 2'h0};
	localparam logic [17:0] A_CH = {IDX_CFG_HI, 2'h0};
	// style codes for pins 0..7: high bits in the upper byte, low bits in the lower
	localparam logic [15:0] CFG_W = 16'hCCAA;
	ebp_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pu), .pull_down_en(pd), .analog_input_line(ain));
	ebp_board board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
		.pull_down_en(pd), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t pins %h expected %h", $time, got, exp);
		end
	endtask
	task chkw(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask
	// both channels offered together; each released on its own handshake
	// one edge between calls so bready is never lowered and raised in one step
	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		bit aw, w, b;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!b && n < 50) begin
			@(posedge aclk);
			n++;
			if (aw && w && bvalid) begin
				b = 1;
				bready <= 1'h0;
				chkw({30'h0, bresp}, {30'h0, er});
			end
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'h0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'h0;
			end
		end
		if (!b) begin
			fails++;
			$display("BAD %0t write response never came", $time);
		end
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit ar, r;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!r && n < 50) begin
			@(posedge aclk);
			n++;
			if (ar && rvalid) begin
				r = 1;
				rready <= 1'h0;
				chkw(rdata, ed);
				chkw({30'h0, rresp}, {30'h0, er});
			end
			if (!ar && arready) begin
				ar = 1;
				arvalid <= 1'h0;
			end
		end
		if (!r) begin
			fails++;
			$display("BAD %0t read data never came", $time);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(A_LV, 32'h0, RESP_OKAY);
		rd(A_DR, 32'h0, RESP_OKAY);
		rd(A_CL, 32'h0, RESP_OKAY);
		rd(A_CH, 32'h0, RESP_OKAY);
		chk(pin_oe, 8'h00);
		chk(ain, 8'hFF);
	endtask
	// pins 0..7 carry style codes 0,1,2,3,0,1,2,3
	task t_out(input logic [7:0] lv);
		logic [7:0] eo, ev;
		wr(A_LV, {24'h0, lv}, 4'h1, RESP_OKAY);
		wr(A_CL, {16'h0000, CFG_W}, 4'h3, RESP_OKAY);
		@(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			case ({CFG_W[8+i], CFG_W[i]})
				2'h1: {eo[i], ev[i]} = {lv[i], lv[i]};
				2'h2: {eo[i], ev[i]} = {~lv[i], 1'h0};
				2'h3: {eo[i], ev[i]} = {1'h1, lv[i]};
				default: {eo[i], ev[i]} = 2'h0;
			endcase
		end
		chk(pin_oe, eo);
		chk(pin_out & eo, ev);
		chk(ain, 8'h11);
		rd(A_LV, {24'h0, lv}, RESP_OKAY);
	endtask
	task t_in;
		wr(A_DR, 32'h0000_00FF, 4'h1, RESP_OKAY);
		ext_en <= 8'hFF;
		ext_val <= 8'h3C;
		repeat (3) @(posedge aclk);
		chk(pin_oe, 8'h00);
		chk(pu, 8'h44);
		chk(pd, 8'h22);
		rd(A_LV, 32'h0000_003C, RESP_OKAY);
	endtask
	// low pins read the wire, high pins the stored level
	task t_mix;
		wr(A_DR, 32'h0000_000F, 4'h1, RESP_OKAY);
		ext_en <= 8'h0F;
		ext_val <= 8'h09;
		repeat (3) @(posedge aclk);
		rd(A_LV, 32'h0000_0059, RESP_OKAY);
		wr(A_CH, 32'h0000_0011, 4'h1, RESP_OKAY);
		rd(A_CL, 32'h0000_11AA, RESP_OKAY);
		wr({16'hF234, 2'h0}, 32'h0, 4'h1, RESP_SLVERR);
		rd({16'hF234, 2'h0}, 32'h0, RESP_SLVERR);
	endtask
	// pin 0 steps through every driver style at both levels
	task automatic t_styles;
		logic [1:0] c;
		logic       eo, ev;
		wr(A_DR, 32'h0, 4'h1, RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			c = 2'(k >> 1);
			wr(A_LV, {31'h0, k[0]}, 4'h1, RESP_OKAY);
			wr(A_CL, {23'h0, c[1], 7'h0, c[0]}, 4'h3, RESP_OKAY);
			@(posedge aclk);
			case (c)
				CFG_POD: {eo, ev} = {k[0], k[0]};
				CFG_NOD: {eo, ev} = {~k[0], 1'h0};
				CFG_CMOS: {eo, ev} = {1'h1, k[0]};
				default: {eo, ev} = 2'h0;
			endcase
			chk({7'h0, pin_oe[0]}, {7'h0, eo});
			chk({7'h0, pin_out[0] & eo}, {7'h0, ev});
			chk({7'h0, ain[0]}, {7'h0, c == CFG_HIZ});
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	// whole run is under two hundred cycles
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		give_verdict;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb, ext_val, ext_en} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset;
		t_out(8'hA5);
		t_out(8'h5A);
		t_in;
		t_mix;
		t_styles;
		give_verdict;
	end
endmodule
`default_nettype wire
